// ==== rtl/cbe_regs.v ====
// Control register slice: receive queue zero word status, packet memory
// self-test control with direct RAM path, PHY management and EEPROM control.
// Assumes external queue, self-test, management and EEPROM engines on i_mclk.
//
// Contract
// - Status bit 24 flags next queue-zero word as end of frame.
// - Status bit 16 set while queue zero empty; reads one after reset.
// - Status bits 1:0 give valid byte count of next queue-zero word.
// - Writing one to self-test bit 31 launches selected test; write-only.
// - Bit 30 fail, bit 29 pass, read-only; reset pass=1, fail=0.
// - Bit 20 set: RAM address advances after each direct RAM access.
// - Bit 19 enables packet-memory self-test mode.
// - Field 18:16 selects test; 000 and 111 reserved; resets to 000.
// - Field 13:0 holds direct RAM word address; resets to zero.
// - Direct data accesses reach packet memory only in direct RAM mode.
// - Management data bits 15:0 hold PHY write or read value.
// - Management bit 12 set omits the 32-bit preamble.
// - Management bit 11 starts transfer; hardware clears it when done.
// - Management bit 10: one writes PHY, zero reads into data register.
// - PHY address in 9:5, register in 4:0, read-write, reset zero.
// - EEPROM data bits 15:0 hold word to write or word read.
// - EEPROM bit 8 starts transfer; hardware clears it when done.
// - EEPROM field 7:6: 11 erase, 10 read, 01 write, 00 enable/disable.
// - Opcode 00: address 5:4 of 11 enables, 00 disables writing.
// - EEPROM bits 5:0 hold word address; reset zero.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "cbe_regs_map.vh"

module cbe_regs #(
  parameter RAM_AW = 14,
  parameter RAM_DW = 32
) (
  input  wire              i_mclk,
  input  wire              i_nrst,
  // Register port
  input  wire [11:0]       i_addr,
  input  wire [31:0]       i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [31:0]       o_rdata,
  // Receive queue zero state
  input  wire              i_rxq_eof,
  input  wire              i_rxq_empty,
  input  wire [1:0]        i_rxq_size,
  // Self-test engine
  output reg               o_st_start,
  output wire              o_st_enable,
  output wire [2:0]        o_st_mode,
  input  wire              i_st_done,
  input  wire              i_st_pass,
  // Packet memory direct path
  output reg               o_ram_wr,
  output reg               o_ram_rd,
  output reg  [RAM_AW-1:0] o_ram_addr,
  output reg  [RAM_DW-1:0] o_ram_wdata,
  input  wire [RAM_DW-1:0] i_ram_rdata,
  // Management engine
  output reg               o_mgmt_start,
  output wire              o_mgmt_no_preamble,
  output wire              o_mgmt_write,
  output wire [4:0]        o_mgmt_phy_addr,
  output wire [4:0]        o_mgmt_phy_reg,
  output wire [15:0]       o_mgmt_wdata,
  input  wire              i_mgmt_done,
  input  wire [15:0]       i_mgmt_rdata,
  // EEPROM engine
  output reg               o_ee_start,
  output wire [1:0]        o_ee_op,
  output wire [5:0]        o_ee_addr,
  output wire [15:0]       o_ee_wdata,
  input  wire              i_ee_done,
  input  wire [15:0]       i_ee_rdata
);

  // ****************************************
  // Decode helper
  // ****************************************
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Engine word: a read result from the engine wins over a software write
  // landing in the same cycle, so a completed read is never lost.
  function [15:0] word_next;
    input        take_eng;
    input [15:0] eng_word;
    input        take_sw;
    input [15:0] sw_word;
    input [15:0] cur;
    begin
      if (take_eng)
        word_next = eng_word;
      else if (take_sw)
        word_next = sw_word;
      else
        word_next = cur;
    end
  endfunction

  // Engine busy bit: set only by a start written while idle, cleared by the
  // engine's done pulse. A control write during busy is dropped whole.
  function busy_next;
    input busy;
    input wr_ctl;
    input start_bit;
    input done;
    begin
      if (wr_ctl & ~busy)
        busy_next = start_bit;
      else if (done)
        busy_next = 1'b0;
      else
        busy_next = busy;
    end
  endfunction

  wire wr_st   = i_wr & hit(i_addr, `CBE_OFF_ST_CTRL);
  wire wr_ram  = i_wr & hit(i_addr, `CBE_OFF_RAM_DATA);
  wire rd_ram  = i_rd & hit(i_addr, `CBE_OFF_RAM_DATA);
  wire wr_mgd  = i_wr & hit(i_addr, `CBE_OFF_MGMT_DATA);
  wire wr_mgc  = i_wr & hit(i_addr, `CBE_OFF_MGMT_CTRL);
  wire wr_eed  = i_wr & hit(i_addr, `CBE_OFF_EE_DATA);
  wire wr_eec  = i_wr & hit(i_addr, `CBE_OFF_EE_CTRL);

  // ****************************************
  // Self-test control
  // ****************************************
  reg              st_fail_reg;
  reg              st_pass_reg;
  reg              st_autoinc_reg;
  reg              st_en_reg;
  reg [2:0]        st_mode_reg;
  reg [RAM_AW-1:0] ram_addr_reg;

  wire bypass = (st_mode_reg == `CBE_MODE_BYPASS);
  wire ram_acc = (wr_ram | rd_ram) & bypass;

  assign o_st_enable = st_en_reg;
  assign o_st_mode   = st_mode_reg;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_fail_reg    <= 1'b0;
      st_pass_reg    <= 1'b1;
      st_autoinc_reg <= 1'b1;
      st_en_reg      <= 1'b0;
      st_mode_reg    <= 3'h0;
      ram_addr_reg   <= {RAM_AW{1'b0}};
      o_st_start     <= 1'b0;
    end else begin
      o_st_start <= wr_st & i_wdata[`CBE_ST_START_BIT];
      if (i_st_done) begin
        st_pass_reg <= i_st_pass;
        st_fail_reg <= ~i_st_pass;
      end else if (wr_st & i_wdata[`CBE_ST_START_BIT]) begin
        st_pass_reg <= 1'b0;
        st_fail_reg <= 1'b0;
      end
      if (wr_st) begin
        st_autoinc_reg <= i_wdata[`CBE_ST_AUTOINC_BIT];
        st_en_reg      <= i_wdata[`CBE_ST_EN_BIT];
        st_mode_reg    <= i_wdata[`CBE_ST_MODE_HI:`CBE_ST_MODE_LO];
        ram_addr_reg   <= i_wdata[RAM_AW-1:0];
      end else if (ram_acc & st_autoinc_reg) begin
        ram_addr_reg <= ram_addr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Direct RAM strobes and address registered. The memory must answer a
  // read combinationally in the strobe's cycle, because the bus expects the
  // word in the cycle right after the read strobe.
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ram_wr    <= 1'b0;
      o_ram_rd    <= 1'b0;
      o_ram_addr  <= {RAM_AW{1'b0}};
      o_ram_wdata <= {RAM_DW{1'b0}};
    end else begin
      o_ram_wr <= wr_ram & bypass;
      o_ram_rd <= rd_ram & bypass;
      if (ram_acc) begin
        o_ram_addr  <= ram_addr_reg;
        o_ram_wdata <= i_wdata[RAM_DW-1:0];
      end
    end
  end

  // ****************************************
  // PHY management
  // ****************************************
  reg [15:0] mg_data_reg;
  reg        mg_nopre_reg;
  reg        mg_busy_reg;
  reg        mg_wr_reg;
  reg [4:0]  mg_phy_reg;
  reg [4:0]  mg_regno_reg;

  assign o_mgmt_no_preamble = mg_nopre_reg;
  assign o_mgmt_write       = mg_wr_reg;
  assign o_mgmt_phy_addr    = mg_phy_reg;
  assign o_mgmt_phy_reg     = mg_regno_reg;
  assign o_mgmt_wdata       = mg_data_reg;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mg_data_reg  <= 16'h0000;
      mg_nopre_reg <= 1'b0;
      mg_busy_reg  <= 1'b0;
      mg_wr_reg    <= 1'b0;
      mg_phy_reg   <= 5'h00;
      mg_regno_reg <= 5'h00;
      o_mgmt_start <= 1'b0;
    end else begin
      o_mgmt_start <= 1'b0;
      // Completion returns read data; a write during busy is not guarded
      mg_data_reg <= word_next(i_mgmt_done & mg_busy_reg & ~mg_wr_reg,
                               i_mgmt_rdata, wr_mgd, i_wdata[15:0], mg_data_reg);
      mg_busy_reg <= busy_next(mg_busy_reg, wr_mgc, i_wdata[`CBE_MG_BUSY_BIT],
                               i_mgmt_done);
      if (wr_mgc & ~mg_busy_reg) begin
        mg_nopre_reg <= i_wdata[`CBE_MG_NOPRE_BIT];
        mg_wr_reg    <= i_wdata[`CBE_MG_WR_BIT];
        mg_phy_reg   <= i_wdata[9:5];
        mg_regno_reg <= i_wdata[4:0];
        o_mgmt_start <= i_wdata[`CBE_MG_BUSY_BIT];
      end
    end
  end

  // ****************************************
  // EEPROM
  // ****************************************
  reg [15:0] ee_data_reg;
  reg        ee_busy_reg;
  reg [1:0]  ee_op_reg;
  reg [5:0]  ee_addr_reg;

  assign o_ee_op    = ee_op_reg;
  assign o_ee_addr  = ee_addr_reg;
  assign o_ee_wdata = ee_data_reg;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ee_data_reg <= 16'h0000;
      ee_busy_reg <= 1'b0;
      ee_op_reg   <= 2'h0;
      ee_addr_reg <= 6'h00;
      o_ee_start  <= 1'b0;
    end else begin
      o_ee_start <= 1'b0;
      ee_data_reg <= word_next(i_ee_done & ee_busy_reg & (ee_op_reg == 2'h2),
                               i_ee_rdata, wr_eed, i_wdata[15:0], ee_data_reg);
      ee_busy_reg <= busy_next(ee_busy_reg, wr_eec, i_wdata[`CBE_EE_BUSY_BIT],
                               i_ee_done);
      if (wr_eec & ~ee_busy_reg) begin
        ee_op_reg   <= i_wdata[7:6];
        ee_addr_reg <= i_wdata[5:0];
        o_ee_start  <= i_wdata[`CBE_EE_BUSY_BIT];
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  reg [31:0] rd_next;
  reg        rd_ram_reg;
  reg [31:0] rdata_reg;
  reg [31:0] ram_rd_word;

  always @* begin
    rd_next = 32'h00000000;
    case (i_addr)
      `CBE_OFF_RXQ_STAT: begin
        rd_next[`CBE_RXQ_EOF_BIT]   = i_rxq_eof;
        rd_next[`CBE_RXQ_EMPTY_BIT] = i_rxq_empty;
        rd_next[1:0]                = i_rxq_size;
      end
      `CBE_OFF_ST_CTRL: begin
        rd_next[`CBE_ST_FAIL_BIT]    = st_fail_reg;
        rd_next[`CBE_ST_PASS_BIT]    = st_pass_reg;
        rd_next[`CBE_ST_AUTOINC_BIT] = st_autoinc_reg;
        rd_next[`CBE_ST_EN_BIT]      = st_en_reg;
        rd_next[18:16]               = st_mode_reg;
        rd_next[RAM_AW-1:0]          = ram_addr_reg;
      end
      // Direct RAM word is steered in after the register stage, not here
      `CBE_OFF_RAM_DATA:  rd_next = 32'h00000000;
      `CBE_OFF_MGMT_DATA: rd_next[15:0] = mg_data_reg;
      `CBE_OFF_MGMT_CTRL: begin
        rd_next[`CBE_MG_NOPRE_BIT] = mg_nopre_reg;
        rd_next[`CBE_MG_BUSY_BIT]  = mg_busy_reg;
        rd_next[`CBE_MG_WR_BIT]    = mg_wr_reg;
        rd_next[9:5]               = mg_phy_reg;
        rd_next[4:0]               = mg_regno_reg;
      end
      `CBE_OFF_EE_DATA:   rd_next[15:0] = ee_data_reg;
      `CBE_OFF_EE_CTRL: begin
        rd_next[`CBE_EE_BUSY_BIT] = ee_busy_reg;
        rd_next[7:6]              = ee_op_reg;
        rd_next[5:0]              = ee_addr_reg;
      end
      default:            rd_next = 32'h00000000;
    endcase
  end

  // Register read data stand for the one cycle after the read strobe
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg  <= 32'h00000000;
      rd_ram_reg <= 1'b0;
    end else begin
      rd_ram_reg <= rd_ram & bypass;
      if (i_rd)
        rdata_reg <= rd_next;
      else
        rdata_reg <= 32'h00000000;
    end
  end

  // ****************************************
  // Direct RAM read return
  // ****************************************
  // The memory word goes onto the bus in the cycle after the read strobe.
  // This leaves a memory-to-bus path in one clock; RAM_DW up to 32 only.
  always @* begin
    ram_rd_word             = 32'h00000000;
    ram_rd_word[RAM_DW-1:0] = i_ram_rdata;
  end

  always @* begin
    if (rd_ram_reg)
      o_rdata = ram_rd_word;
    else
      o_rdata = rdata_reg;
  end

endmodule // cbe_regs

// ==== rtl/cbe_regs_map.vh ====
// Offsets, field positions and reset values of the self-test, management
// and EEPROM register slice. Included by cbe_regs.v only.
`ifndef CBE_REGS_MAP_VH
`define CBE_REGS_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CBE_OFF_RXQ_STAT   12'h134
`define CBE_OFF_ST_CTRL    12'h138
`define CBE_OFF_RAM_DATA   12'h13C
`define CBE_OFF_MGMT_DATA  12'h140
`define CBE_OFF_MGMT_CTRL  12'h144
`define CBE_OFF_EE_DATA    12'h148
`define CBE_OFF_EE_CTRL    12'h14C

// ****************************************
// Reset values
// ****************************************
`define CBE_RST_RXQ_STAT   32'h00010000
`define CBE_RST_ST_CTRL    32'h20100000
`define CBE_RST_MGMT_DATA  32'h00000000
`define CBE_RST_MGMT_CTRL  32'h00000000
`define CBE_RST_EE_DATA    32'h00000000
`define CBE_RST_EE_CTRL    32'h00000000

// ****************************************
// Field positions
// ****************************************
`define CBE_RXQ_EOF_BIT    24
`define CBE_RXQ_EMPTY_BIT  16
`define CBE_ST_START_BIT   31
`define CBE_ST_FAIL_BIT    30
`define CBE_ST_PASS_BIT    29
`define CBE_ST_AUTOINC_BIT 20
`define CBE_ST_EN_BIT      19
`define CBE_ST_MODE_HI     18
`define CBE_ST_MODE_LO     16
`define CBE_ST_ADDR_HI     13
`define CBE_MG_NOPRE_BIT   12
`define CBE_MG_BUSY_BIT    11
`define CBE_MG_WR_BIT      10
`define CBE_EE_BUSY_BIT    8

// ****************************************
// Self-test mode codes
// ****************************************
`define CBE_MODE_PATTERN   3'h1
`define CBE_MODE_FILL0     3'h2
`define CBE_MODE_READ0     3'h3
`define CBE_MODE_FILL1     3'h4
`define CBE_MODE_READ1     3'h5
`define CBE_MODE_BYPASS    3'h6

`endif

// ==== verif/cbe_regs_checker.sv ====
// Concurrent checks on the register slice ports.
// Assumes one clock domain, i_nrst asynchronous active low.
`timescale 1ns/1ps
module cbe_regs_checker #(
  parameter RAM_DW = 32
) (
  input wire              i_mclk,
  input wire              i_nrst,
  input wire [11:0]       i_addr,
  input wire [31:0]       i_wdata,
  input wire              i_wr,
  input wire              i_rd,
  input wire [31:0]       o_rdata,
  input wire              i_rxq_eof,
  input wire              i_rxq_empty,
  input wire [1:0]        i_rxq_size,
  input wire              o_st_start,
  input wire [2:0]        o_st_mode,
  input wire              o_ram_wr,
  input wire              o_ram_rd,
  input wire [RAM_DW-1:0] o_ram_wdata,
  input wire [RAM_DW-1:0] i_ram_rdata,
  input wire              o_mgmt_start,
  input wire              o_mgmt_write,
  input wire [4:0]        o_mgmt_phy_addr,
  input wire              o_ee_start,
  input wire [1:0]        o_ee_op,
  input wire [5:0]        o_ee_addr
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  a_rd_status: assert property (i_rd && i_addr == 12'h134 |=> o_rdata == {7'h0,
    $past(i_rxq_eof), 7'h0, $past(i_rxq_empty), 14'h0, $past(i_rxq_size)})
    else $error("status read mismatch");
  a_rd_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside read");
  a_st_pulse: assert property (i_wr && i_addr == 12'h138 |=> o_st_start == $past(i_wdata[31]))
    else $error("self-test start pulse wrong");
  a_st_mode: assert property (i_wr && i_addr == 12'h138 |=> o_st_mode == $past(i_wdata[18:16]))
    else $error("test mode not taken");
  a_ram_gate: assert property (i_wr && i_addr == 12'h13C |=> o_ram_wr == ($past(o_st_mode) == 3'h6))
    else $error("direct ram write gating wrong");
  a_ram_data: assert property (o_ram_wr |-> o_ram_wdata == $past(i_wdata))
    else $error("direct ram data wrong");
  a_ram_rd_gate: assert property (i_rd && i_addr == 12'h13C |=>
    o_ram_rd == ($past(o_st_mode) == 3'h6))
    else $error("direct ram read gating wrong");
  a_ram_rd_data: assert property (o_ram_rd |-> o_rdata[RAM_DW-1:0] == i_ram_rdata)
    else $error("direct ram read data not returned");
  a_mgmt_req: assert property (o_mgmt_start |-> $past(i_addr) == 12'h144 &&
    o_mgmt_write == $past(i_wdata[10]) && o_mgmt_phy_addr == $past(i_wdata[9:5]))
    else $error("management request fields wrong");
  a_ee_req: assert property (o_ee_start |-> $past(i_addr) == 12'h14C &&
    o_ee_op == $past(i_wdata[7:6]) && o_ee_addr == $past(i_wdata[5:0]))
    else $error("eeprom request fields wrong");
endmodule // cbe_regs_checker

bind cbe_regs cbe_regs_checker #(.RAM_DW(RAM_DW)) u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rxq_eof(i_rxq_eof), .i_rxq_empty(i_rxq_empty), .i_rxq_size(i_rxq_size),
  .o_st_start(o_st_start), .o_st_mode(o_st_mode), .o_ram_wr(o_ram_wr),
  .o_ram_rd(o_ram_rd), .i_ram_rdata(i_ram_rdata),
  .o_ram_wdata(o_ram_wdata), .o_mgmt_start(o_mgmt_start), .o_mgmt_write(o_mgmt_write),
  .o_mgmt_phy_addr(o_mgmt_phy_addr), .o_ee_start(o_ee_start), .o_ee_op(o_ee_op),
  .o_ee_addr(o_ee_addr));

// ==== verif/cbe_regs_tb.sv ====
// Self-checking bench for cbe_regs: register tasks, engines played by hand.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module cbe_regs_tb;
  reg         i_mclk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  reg  [11:0] i_addr = 12'h000;
  reg  [31:0] i_wdata = 32'h0;
  reg         i_rxq_eof = 1'b0, i_rxq_empty = 1'b1, i_st_done = 1'b0, i_st_pass = 1'b0;
  reg  [1:0]  i_rxq_size = 2'h0;
  reg         i_mgmt_done = 1'b0, i_ee_done = 1'b0;
  reg  [15:0] i_mgmt_rdata = 16'h1234, i_ee_rdata = 16'hC3C3;
  reg  [31:0] i_ram_rdata = 32'h5AC30F96;
  wire [31:0] o_rdata, o_ram_wdata;
  wire [13:0] o_ram_addr;
  wire [2:0]  o_st_mode;
  wire [4:0]  o_mgmt_phy_addr, o_mgmt_phy_reg;
  wire [15:0] o_mgmt_wdata, o_ee_wdata;
  wire [1:0]  o_ee_op;
  wire [5:0]  o_ee_addr;
  wire        o_st_start, o_st_enable, o_ram_wr, o_ram_rd, o_mgmt_start, o_mgmt_no_preamble;
  wire        o_mgmt_write, o_ee_start;
  integer     error_cnt = 0, n_checks = 0, cyc = 0, m;

  cbe_regs dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxq_eof(i_rxq_eof),
    .i_rxq_empty(i_rxq_empty), .i_rxq_size(i_rxq_size), .o_st_start(o_st_start),
    .o_st_enable(o_st_enable), .o_st_mode(o_st_mode), .i_st_done(i_st_done),
    .i_st_pass(i_st_pass), .o_ram_wr(o_ram_wr), .o_ram_rd(o_ram_rd), .o_ram_addr(o_ram_addr),
    .o_ram_wdata(o_ram_wdata), .i_ram_rdata(i_ram_rdata), .o_mgmt_start(o_mgmt_start),
    .o_mgmt_no_preamble(o_mgmt_no_preamble), .o_mgmt_write(o_mgmt_write),
    .o_mgmt_phy_addr(o_mgmt_phy_addr), .o_mgmt_phy_reg(o_mgmt_phy_reg),
    .o_mgmt_wdata(o_mgmt_wdata), .i_mgmt_done(i_mgmt_done), .i_mgmt_rdata(i_mgmt_rdata),
    .o_ee_start(o_ee_start), .o_ee_op(o_ee_op), .o_ee_addr(o_ee_addr),
    .o_ee_wdata(o_ee_wdata), .i_ee_done(i_ee_done), .i_ee_rdata(i_ee_rdata));

  always #2 i_mclk = ~i_mclk;

  task wrap_up;
    begin
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Hang guard: whole sequence needs well under 1000 cycles
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Bus access: strobe for one cycle; outputs looked at just after the next edge
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
    end
  endtask

  task rd(input [11:0] a, input [31:0] exp);
    begin
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
    end
  endtask

  // One-cycle completion pulse: 0 self-test, 1 management, 2 eeprom
  task done(input integer w);
    begin
      @(posedge i_mclk);
      i_st_done <= (w == 0);
      i_mgmt_done <= (w == 1);
      i_ee_done <= (w == 2);
      @(posedge i_mclk);
      {i_st_done, i_mgmt_done, i_ee_done} <= 3'h0;
      #1;
    end
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(12'h134, 32'h00010000);
    rd(12'h138, 32'h20100000);
    rd(12'h140, 32'h0);
    rd(12'h144, 32'h0);
    rd(12'h14C, 32'h0);
    rd(12'h150, 32'h0);
    @(posedge i_mclk);
    i_rxq_eof <= 1'b1;
    i_rxq_empty <= 1'b0;
    i_rxq_size <= 2'h3;
    rd(12'h134, 32'h01000003);
    rd(12'h134, 32'h01000003);
    wr(12'h138, 32'h800A0000);
    chk({o_st_start, o_st_enable, o_st_mode}, 32'h1A);
    rd(12'h138, 32'h000A0000);
    done(0);
    rd(12'h138, 32'h400A0000);
    @(posedge i_mclk);
    i_st_pass <= 1'b1;
    done(0);
    rd(12'h138, 32'h200A0000);
    for (m = 0; m < 8; m = m + 1) begin
      wr(12'h138, m << 16);
      chk(o_st_mode, m);
    end
    wr(12'h138, 32'h00163FFE);
    wr(12'h13C, 32'hA5A5A5A5);
    chk({o_ram_wr, o_ram_addr}, 32'h7FFE);
    chk(o_ram_wdata, 32'hA5A5A5A5);
    rd(12'h138, 32'h20163FFF);
    rd(12'h13C, 32'h5AC30F96);
    chk({o_ram_rd, o_ram_addr}, 32'h7FFF);
    rd(12'h138, 32'h20160000);
    wr(12'h138, 32'h00063FFF);
    wr(12'h13C, 32'h1);
    rd(12'h138, 32'h20063FFF);
    wr(12'h138, 32'h00023FFF);
    wr(12'h13C, 32'h2);
    chk(o_ram_wr, 32'h0);
    rd(12'h13C, 32'h0);
    chk(o_ram_rd, 32'h0);
    wr(12'h140, 32'h0000BEEF);
    wr(12'h144, 32'h00001EAA);
    chk({o_mgmt_start, o_mgmt_no_preamble, o_mgmt_write, o_mgmt_phy_addr, o_mgmt_phy_reg},
        32'h1EAA);
    chk(o_mgmt_wdata, 32'hBEEF);
    wr(12'h144, 32'h0);
    rd(12'h144, 32'h00001EAA);
    done(1);
    rd(12'h144, 32'h000016AA);
    rd(12'h140, 32'h0000BEEF);
    wr(12'h144, 32'h00000803);
    done(1);
    rd(12'h144, 32'h00000003);
    rd(12'h140, 32'h00001234);
    wr(12'h148, 32'h00005A5A);
    chk(o_ee_wdata, 32'h5A5A);
    for (m = 0; m < 5; m = m + 1) begin
      wr(12'h14C, (m < 4) ? (32'h130 | (m << 6)) : 32'h100);
      chk({o_ee_start, o_ee_op, o_ee_addr}, (m < 4) ? (32'h130 | (m << 6)) : 32'h100);
      done(2);
      rd(12'h14C, (m < 4) ? (32'h30 | (m << 6)) : 32'h0);
    end
    rd(12'h148, 32'h0000C3C3);
    // Mid-run reset must bring self-test control, management control and EEPROM data back to reset values
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(12'h138, 32'h20100000);
    rd(12'h144, 32'h0);
    rd(12'h148, 32'h0);
    wrap_up;
  end
endmodule // cbe_regs_tb
